/* File: rtl/wcmp_pkg.sv */
`default_nettype none
package wcmp_pkg;
    localparam int          DATA_W          = 12;
    localparam int          HYS_W           = 6;
    localparam int          EVC_W           = 4;
    localparam int          CNT_W           = EVC_W + 1;
    localparam logic [7:0]  ADDR_FIRST_ID   = 8'h03;
    localparam logic [7:0]  ADDR_LOW_FLAGS  = 8'h0C;
    localparam logic [7:0]  ADDR_EVC        = 8'h36;
    localparam logic [7:0]  ADDR_UTH_LOW    = 8'h3C;
    localparam logic [7:0]  ADDR_UTH_TOP    = 8'h3D;
    localparam logic [7:0]  ADDR_LTH_LOW    = 8'h3E;
    localparam logic [7:0]  ADDR_LTH_TOP    = 8'h3F;
    localparam logic [7:0]  ADDR_HYS        = 8'h41;
    localparam int          EVC_LSB         = 4;
    localparam int          FIRST_ID_LSB    = 4;
    localparam logic [3:0]  ID_CHANNEL_ZERO = 4'h0;
    localparam logic [3:0]  ID_CHANNEL_ONE  = 4'h1;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
endpackage : wcmp_pkg
`default_nettype wire

/* File: rtl/wcmp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface wcmp_if;
    import wcmp_pkg::*;
    logic                ce;
    logic                enable;
    logic                valid;
    logic [DATA_W-1:0]   data;
    logic [DATA_W-1:0]   upper;
    logic [DATA_W-1:0]   lower;
    logic [HYS_W-1:0]    hys;
    logic [CNT_W-1:0]    limit;
    logic                low_hit;
    logic                high_hit;
    modport ctl (output ce, enable, valid, data, upper, lower, hys, limit,
                 input low_hit, high_hit);
    modport cmp (input ce, enable, valid, data, upper, lower, hys, limit,
                 output low_hit, high_hit);
endinterface : wcmp_if
`default_nettype wire

/* File: rtl/wcmp_chan.sv */
`timescale 1ns/10ps
`default_nettype none
module wcmp_chan (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Comparator link.
    wcmp_if.cmp       cmp
);
    import wcmp_pkg::*;

    typedef struct packed {
        logic             low_act;
        logic             high_act;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic             low_hit;
        logic             high_hit;
    } wcmp_chan_t;

    wcmp_chan_t st_r;
    wcmp_chan_t st_nxt;
    logic [DATA_W:0] low_release;
    logic [DATA_W:0] high_release;

    // Release points sit one hysteresis step inside each limit.
    assign low_release  = {1'b0, cmp.lower} + {{(DATA_W+1-HYS_W){1'b0}},
                          cmp.hys};
    assign high_release = {1'b0, cmp.upper} - {{(DATA_W+1-HYS_W){1'b0}},
                          cmp.hys};

    always_comb begin
        st_nxt = st_r;
        st_nxt.low_hit = 1'b0;
        st_nxt.high_hit = 1'b0;
        if (!cmp.enable) begin
            st_nxt = '0;
        end else if (cmp.valid) begin
            st_nxt.low_act = st_r.low_act
                ? ({1'b0, cmp.data} <= low_release)
                : (cmp.data <= cmp.lower);
            st_nxt.high_act = st_r.high_act
                ? ({1'b0, cmp.data} >= high_release)
                : (cmp.data >= cmp.upper);
            if (st_nxt.low_act) begin
                if (st_r.low_cnt != cmp.limit) begin
                    st_nxt.low_cnt = st_r.low_cnt + 1'b1;
                end
                st_nxt.low_hit = (st_r.low_cnt + 1'b1) == cmp.limit;
            end else begin
                st_nxt.low_cnt = '0;
            end
            if (st_nxt.high_act) begin
                if (st_r.high_cnt != cmp.limit) begin
                    st_nxt.high_cnt = st_r.high_cnt + 1'b1;
                end
                st_nxt.high_hit = (st_r.high_cnt + 1'b1) == cmp.limit;
            end else begin
                st_nxt.high_cnt = '0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else if (cmp.ce) begin
            st_r <= st_nxt;
        end
    end

    assign cmp.low_hit  = st_r.low_hit;
    assign cmp.high_hit = st_r.high_hit;

    a_hit_needs_act: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r.low_hit |-> st_r.low_act && st_r.low_cnt == cmp.limit)
        else $error("low hit without full active run");
    a_cnt_restart: assert property (@(posedge clk_in) disable iff (rst_in)
        cmp.ce && cmp.enable && cmp.valid && !st_nxt.low_act
        |=> st_r.low_cnt == '0)
        else $error("count not restarted by inactive result");
endmodule : wcmp_chan
`default_nettype wire

/* File: rtl/wcmp_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module wcmp_regs (
    // Clock, reset and clock enable.
    input  wire logic                          CORE_CLK_IN,
    input  wire logic                          RST_IN,
    input  wire logic                          CE_IN,
    // Register port.
    input  wire logic                          REG_WR_IN,
    input  wire logic                          REG_RD_IN,
    input  wire logic [7:0]                    REG_ADDR_IN,
    input  wire logic [7:0]                    REG_WDATA_IN,
    output logic      [7:0]                    REG_RDATA_OUT,
    // Control bits held elsewhere in the device.
    input  wire logic                          GCALL_RST_IN,
    input  wire logic                          SEQUENCE_GO_BIT_IN,
    input  wire logic                          COMPARATOR_BLOCK_ON_IN,
    input  wire logic                          ALERT_ALLOW_FIRST_CHANNEL_IN,
    input  wire logic                          ALERT_ALLOW_SECOND_CHANNEL_IN,
    // Channel zero limits held elsewhere in the device.
    input  wire logic [wcmp_pkg::DATA_W-1:0]   CH0_UPPER_IN,
    input  wire logic [wcmp_pkg::DATA_W-1:0]   CH0_LOWER_IN,
    input  wire logic [wcmp_pkg::HYS_W-1:0]    CH0_HYS_IN,
    // Conversion results.
    input  wire logic                          CONV_VALID_IN,
    input  wire logic                          CONV_CHANNEL_IN,
    input  wire logic [wcmp_pkg::DATA_W-1:0]   CONV_DATA_IN,
    // Alert state.
    output logic      [1:0]                    LOW_FLAGS_OUT,
    output logic      [3:0]                    FIRST_ALERT_CHANNEL_ID_OUT,
    output logic                               ALERT_OUT
);
    import wcmp_pkg::*;

    typedef struct packed {
        logic [3:0]       uth_top;
        logic [7:0]       uth_low;
        logic [3:0]       lth_top;
        logic [7:0]       lth_low;
        logic [HYS_W-1:0] hys;
        logic [EVC_W-1:0] evc;
        logic [3:0]       first_id;
        logic             first_vld;
        logic [1:0]       low_flags;
        logic [7:0]       rdata;
    } wcmp_state_t;

    wcmp_state_t st_r;
    wcmp_state_t st_nxt;
    wcmp_if      if0 ();
    wcmp_if      if1 ();
    logic [1:0]  allow;
    logic [1:0]  low_evt;
    logic [1:0]  any_evt;

    function automatic logic [DATA_W-1:0] join_limit(input logic [3:0] top,
                                                     input logic [7:0] low);
        join_limit = {top, low};
    endfunction

    function automatic logic [7:0] read_mux(input wcmp_state_t s,
                                            input logic [7:0] a);
        case (a)
            ADDR_FIRST_ID:  read_mux = {s.first_id, 4'h0};
            ADDR_LOW_FLAGS: read_mux = {6'h00, s.low_flags};
            ADDR_EVC:       read_mux = {s.evc, 4'h0};
            ADDR_UTH_LOW:   read_mux = s.uth_low;
            ADDR_UTH_TOP:   read_mux = {4'h0, s.uth_top};
            ADDR_LTH_LOW:   read_mux = s.lth_low;
            ADDR_LTH_TOP:   read_mux = {4'h0, s.lth_top};
            ADDR_HYS:       read_mux = {2'h0, s.hys};
            default:        read_mux = RESET_BYTE;
        endcase
    endfunction

    // Channel zero comparator.
    assign if0.ce     = CE_IN;
    assign if0.enable = COMPARATOR_BLOCK_ON_IN;
    assign if0.valid  = CONV_VALID_IN && !CONV_CHANNEL_IN;
    assign if0.data   = CONV_DATA_IN;
    assign if0.upper  = CH0_UPPER_IN;
    assign if0.lower  = CH0_LOWER_IN;
    assign if0.hys    = CH0_HYS_IN;
    assign if0.limit  = {1'b0, st_r.evc} + 1'b1;

    // Channel one comparator.
    assign if1.ce     = CE_IN;
    assign if1.enable = COMPARATOR_BLOCK_ON_IN;
    assign if1.valid  = CONV_VALID_IN && CONV_CHANNEL_IN;
    assign if1.data   = CONV_DATA_IN;
    assign if1.upper  = join_limit(st_r.uth_top, st_r.uth_low);
    assign if1.lower  = join_limit(st_r.lth_top, st_r.lth_low);
    assign if1.hys    = st_r.hys;
    assign if1.limit  = {1'b0, st_r.evc} + 1'b1;

    wcmp_chan u_chan0 (
        .clk_in (CORE_CLK_IN),
        .rst_in (RST_IN),
        .cmp    (if0)
    );

    wcmp_chan u_chan1 (
        .clk_in (CORE_CLK_IN),
        .rst_in (RST_IN),
        .cmp    (if1)
    );

    assign allow   = {ALERT_ALLOW_SECOND_CHANNEL_IN,
                      ALERT_ALLOW_FIRST_CHANNEL_IN};
    assign low_evt = {if1.low_hit, if0.low_hit} & allow;
    assign any_evt = low_evt | ({if1.high_hit, if0.high_hit} & allow);

    always_comb begin
        st_nxt = st_r;
        if (REG_RD_IN) begin
            st_nxt.rdata = read_mux(st_r, REG_ADDR_IN);
        end
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                ADDR_UTH_LOW: st_nxt.uth_low = REG_WDATA_IN;
                ADDR_UTH_TOP: st_nxt.uth_top = REG_WDATA_IN[3:0];
                ADDR_LTH_LOW: st_nxt.lth_low = REG_WDATA_IN;
                ADDR_LTH_TOP: st_nxt.lth_top = REG_WDATA_IN[3:0];
                ADDR_HYS:     st_nxt.hys = REG_WDATA_IN[HYS_W-1:0];
                ADDR_EVC:     st_nxt.evc =
                                  REG_WDATA_IN[EVC_LSB+:EVC_W];
                ADDR_LOW_FLAGS: st_nxt.low_flags =
                                  st_r.low_flags & ~REG_WDATA_IN[1:0];
                default: st_nxt.low_flags = st_nxt.low_flags;
            endcase
        end
        // A flag event in the cycle of a flag clearing write still lands.
        st_nxt.low_flags = st_nxt.low_flags | low_evt;
        if (SEQUENCE_GO_BIT_IN) begin
            st_nxt.first_vld = 1'b0;
            st_nxt.first_id  = ID_CHANNEL_ZERO;
        end else if (!st_r.first_vld && any_evt != 2'b00) begin
            st_nxt.first_vld = 1'b1;
            st_nxt.first_id  = any_evt[0] ? ID_CHANNEL_ZERO
                                          : ID_CHANNEL_ONE;
        end
        if (GCALL_RST_IN) begin
            st_nxt.first_vld = 1'b0;
            st_nxt.first_id  = ID_CHANNEL_ZERO;
            st_nxt.low_flags = 2'b00;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_r <= '0;
        end else if (CE_IN) begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA_OUT              = st_r.rdata;
    assign LOW_FLAGS_OUT              = st_r.low_flags;
    assign FIRST_ALERT_CHANNEL_ID_OUT = st_r.first_id;
    assign ALERT_OUT                  = st_r.first_vld;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_flag_sets: assert property (CE_IN && low_evt[1] && !GCALL_RST_IN
        |=> LOW_FLAGS_OUT[1])
        else $error("low flag one not set by its event");
    a_w1c_single: assert property (CE_IN && REG_WR_IN && !GCALL_RST_IN
        && REG_ADDR_IN == ADDR_LOW_FLAGS && REG_WDATA_IN[1:0] == 2'b01
        && low_evt == 2'b00 |=> LOW_FLAGS_OUT == {$past(LOW_FLAGS_OUT[1]),
        1'b0})
        else $error("single flag clear disturbed the other flag");
    a_ff_clears: assert property (CE_IN && REG_WR_IN && low_evt == 2'b00
        && REG_ADDR_IN == ADDR_LOW_FLAGS && REG_WDATA_IN == 8'hFF
        |=> LOW_FLAGS_OUT == 2'b00)
        else $error("FFh write left a flag set");
    a_go_clears_id: assert property (CE_IN && SEQUENCE_GO_BIT_IN
        |=> !ALERT_OUT && FIRST_ALERT_CHANNEL_ID_OUT == ID_CHANNEL_ZERO)
        else $error("sequence go did not clear record");
    a_first_holds: assert property (ALERT_OUT && !$past(ALERT_OUT)
        && !SEQUENCE_GO_BIT_IN && !GCALL_RST_IN
        |=> $stable(FIRST_ALERT_CHANNEL_ID_OUT))
        else $error("first channel record overwritten");
    a_id_one: assert property (CE_IN && !ALERT_OUT && any_evt == 2'b10
        && !SEQUENCE_GO_BIT_IN && !GCALL_RST_IN
        |=> ALERT_OUT && FIRST_ALERT_CHANNEL_ID_OUT == ID_CHANNEL_ONE)
        else $error("channel one not recorded first");
    a_read_resv: assert property (CE_IN && REG_RD_IN
        && REG_ADDR_IN == ADDR_HYS |=> REG_RDATA_OUT[7:6] == 2'b00)
        else $error("reserved hysteresis bits read nonzero");
    a_disabled_quiet: assert property (CE_IN && !COMPARATOR_BLOCK_ON_IN
        |=> !if1.low_hit && !if0.low_hit)
        else $error("comparator fired while block off");
    a_allow_gate: assert property (!ALERT_ALLOW_SECOND_CHANNEL_IN
        |-> !low_evt[1])
        else $error("channel one event passed while not allowed");
    a_limit_wr: assert property (CE_IN && REG_WR_IN
        && REG_ADDR_IN == ADDR_UTH_TOP
        |=> if1.upper[11:8] == $past(REG_WDATA_IN[3:0]))
        else $error("upper top nibble not written");

    c_low_flag: cover property (low_evt[1] ##1 LOW_FLAGS_OUT[1]);
    c_w1c: cover property (REG_WR_IN && REG_ADDR_IN == ADDR_LOW_FLAGS);
    c_first_one: cover property (ALERT_OUT
        && FIRST_ALERT_CHANNEL_ID_OUT == ID_CHANNEL_ONE);
endmodule : wcmp_regs
`default_nettype wire

/* File: bench/wcmp_host.sv */
`timescale 1ns/10ps
`default_nettype none
module wcmp_host (
    // Clock.
    input  wire logic       clk_in,
    // Register port towards the device.
    output logic            wr_out,
    output logic            rd_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out,
    input  wire logic [7:0] rdata_in
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'hA5;
        wdata_out = 8'h5A;
    end

    // Flag clears are only issued between conversions, never beside one.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        rd_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        @(posedge clk_in);
        #1;
        d = rdata_in;
    endtask
endmodule // wcmp_host
`default_nettype wire

/* File: bench/wcmp_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module wcmp_regs_tb;
    import wcmp_pkg::*;
    logic              clk, rst, ce, wr, rd, gcall, go, blk_on;
    logic              allow0, allow1, cvalid, cch, alert;
    logic [7:0]        addr, wdata, rdata, rv, a, d;
    logic [DATA_W-1:0] ch0_up, ch0_lo, cdata;
    logic [HYS_W-1:0]  ch0_hys;
    logic [1:0]        flags;
    logic [3:0]        fid;
    logic [31:0]       lfsr;
    int                n_fail, compares;
    localparam logic [7:0] RW_A [6] = '{ADDR_UTH_LOW, ADDR_UTH_TOP,
        ADDR_LTH_LOW, ADDR_LTH_TOP, ADDR_HYS, ADDR_EVC};
    localparam logic [7:0] ALL_A [10] = '{ADDR_FIRST_ID, ADDR_LOW_FLAGS,
        ADDR_EVC, ADDR_UTH_LOW, ADDR_UTH_TOP, ADDR_LTH_LOW, ADDR_LTH_TOP,
        ADDR_HYS, 8'h37, 8'h7F};
    localparam logic [11:0] EVC_SEQ [7] = '{12'h1F4, 12'h032, 12'h032,
        12'h1F4, 12'h032, 12'h032, 12'h032};
    localparam logic [11:0] HYS_SEQ [4] = '{12'h069, 12'h073, 12'h069, 12'h064};

    wcmp_regs uut (
        .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .GCALL_RST_IN(gcall), .SEQUENCE_GO_BIT_IN(go),
        .COMPARATOR_BLOCK_ON_IN(blk_on),
        .ALERT_ALLOW_FIRST_CHANNEL_IN(allow0),
        .ALERT_ALLOW_SECOND_CHANNEL_IN(allow1),
        .CH0_UPPER_IN(ch0_up), .CH0_LOWER_IN(ch0_lo), .CH0_HYS_IN(ch0_hys),
        .CONV_VALID_IN(cvalid), .CONV_CHANNEL_IN(cch), .CONV_DATA_IN(cdata),
        .LOW_FLAGS_OUT(flags), .FIRST_ALERT_CHANNEL_ID_OUT(fid),
        .ALERT_OUT(alert)
    );

    wcmp_host host (
        .clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .wdata_out(wdata), .rdata_in(rdata)
    );

    always #10 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Bits that a register keeps; everything else must read back as zero.
    function automatic logic [7:0] rb_mask(input logic [7:0] ad);
        case (ad)
            ADDR_UTH_LOW, ADDR_LTH_LOW: return 8'hFF;
            ADDR_UTH_TOP, ADDR_LTH_TOP: return 8'h0F;
            ADDR_HYS: return 8'h3F;
            ADDR_EVC: return 8'hF0;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic st(input logic [1:0] f, input logic al, input logic [3:0] i);
        chk("alert_state", {1'b0, alert, flags, fid}, {1'b0, al, f, i});
    endtask

    // One result, then wait until its flag update has landed.
    task automatic conv(input logic ch, input logic [11:0] v);
        @(posedge clk);
        #1;
        cvalid = 1'b1;
        cch = ch;
        cdata = v;
        @(posedge clk);
        #1;
        cvalid = 1'b0;
        cdata = ~v;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input logic is_gcall);
        @(posedge clk);
        #1;
        if (is_gcall) gcall = 1'b1;
        else go = 1'b1;
        @(posedge clk);
        #1;
        gcall = 1'b0;
        go = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic conclude();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        n_fail++;
        conclude();
    end

    initial begin
        clk = 1'b0; rst = 1'b1; ce = 1'b1; gcall = 1'b0; go = 1'b0;
        blk_on = 1'b1; allow0 = 1'b1; allow1 = 1'b1; cvalid = 1'b0;
        cch = 1'b0; cdata = 12'h000; ch0_up = 12'hFFF; ch0_lo = 12'h0C8;
        ch0_hys = 6'h00; lfsr = 32'hC9FE; n_fail = 0; compares = 0;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        st(2'b00, 1'b0, 4'h0);
        foreach (ALL_A[k]) begin
            host.rd_reg(ALL_A[k], rv);
            chk("reset_value", rv, 8'h00);
        end
        for (int i = 0; i < 30; i++) begin
            lfsr = lfsr_next(lfsr);
            a = (i < 6) ? RW_A[i] : RW_A[lfsr[18:16] % 6];
            d = (i < 6) ? 8'hFF : lfsr[7:0];
            host.wr_reg(a, d);
            host.rd_reg(a, rv);
            chk("rw_readback", rv, d & rb_mask(a));
        end
        host.wr_reg(ADDR_FIRST_ID, 8'hFF);
        host.rd_reg(ADDR_FIRST_ID, rv);
        chk("first_id_ro", rv, 8'h00);
        host.wr_reg(ADDR_UTH_TOP, 8'h0F);
        host.wr_reg(ADDR_UTH_LOW, 8'hFF);
        host.wr_reg(ADDR_LTH_TOP, 8'h00);
        host.wr_reg(ADDR_LTH_LOW, 8'h64);
        host.wr_reg(ADDR_HYS, 8'h00);
        host.wr_reg(ADDR_EVC, 8'h00);
        conv(1'b1, 12'h032);
        st(2'b10, 1'b1, 4'h1);
        host.rd_reg(ADDR_FIRST_ID, rv);
        chk("first_id", rv, 8'h10);
        conv(1'b0, 12'h0C8);
        st(2'b11, 1'b1, 4'h1);
        host.wr_reg(ADDR_LOW_FLAGS, 8'h01);
        host.rd_reg(ADDR_LOW_FLAGS, rv);
        chk("w1c_single", rv, 8'h02);
        host.wr_reg(ADDR_LOW_FLAGS, 8'hFF);
        host.rd_reg(ADDR_LOW_FLAGS, rv);
        chk("w1c_all", rv, 8'h00);
        host.wr_reg(ADDR_EVC, 8'h20);
        foreach (EVC_SEQ[k]) begin
            conv(1'b1, EVC_SEQ[k]);
            st({k == 6, 1'b0}, 1'b1, 4'h1);
        end
        host.wr_reg(ADDR_EVC, 8'h00);
        host.wr_reg(ADDR_HYS, 8'h0A);
        host.wr_reg(ADDR_LOW_FLAGS, 8'hFF);
        conv(1'b1, 12'h1F4);
        conv(1'b1, 12'h032);
        host.wr_reg(ADDR_LOW_FLAGS, 8'h02);
        foreach (HYS_SEQ[k]) begin
            conv(1'b1, HYS_SEQ[k]);
            st({k == 3, 1'b0}, 1'b1, 4'h1);
        end
        pulse(1'b0);
        st(2'b10, 1'b0, 4'h0);
        host.wr_reg(ADDR_LOW_FLAGS, 8'hFF);
        conv(1'b0, 12'h1F4);
        conv(1'b0, 12'h0C8);
        conv(1'b1, 12'h1F4);
        conv(1'b1, 12'h032);
        st(2'b11, 1'b1, 4'h0);
        pulse(1'b1);
        st(2'b00, 1'b0, 4'h0);
        allow1 = 1'b0;
        conv(1'b1, 12'h1F4);
        conv(1'b1, 12'h032);
        st(2'b00, 1'b0, 4'h0);
        allow1 = 1'b1;
        blk_on = 1'b0;
        conv(1'b1, 12'h032);
        st(2'b00, 1'b0, 4'h0);
        blk_on = 1'b1;
        conv(1'b1, 12'h032);
        st(2'b10, 1'b1, 4'h1);
        host.wr_reg(ADDR_LOW_FLAGS, 8'hFF);
        pulse(1'b0);
        host.wr_reg(ADDR_UTH_TOP, 8'h08);
        host.wr_reg(ADDR_UTH_LOW, 8'h00);
        conv(1'b1, 12'h7FF);
        st(2'b00, 1'b0, 4'h0);
        conv(1'b1, 12'h800);
        st(2'b00, 1'b1, 4'h1);
        // A result just inside the high margin must not restart the run.
        pulse(1'b0);
        conv(1'b1, 12'h7F8);
        conv(1'b1, 12'h800);
        st(2'b00, 1'b0, 4'h0);
        conv(1'b1, 12'h7F0);
        conv(1'b1, 12'h800);
        st(2'b00, 1'b1, 4'h1);
        ce = 1'b0;
        host.wr_reg(ADDR_HYS, 8'h3F);
        ce = 1'b1;
        host.rd_reg(ADDR_HYS, rv);
        chk("ce_freeze", rv, 8'h0A);
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        st(2'b00, 1'b0, 4'h0);
        host.rd_reg(ADDR_UTH_TOP, rv);
        chk("mid_reset", rv, 8'h00);
        conclude();
    end
endmodule // wcmp_regs_tb
`default_nettype wire
